// [hw/qpc_pkg.sv]
// Package for the quadrature position counter control block.
// Assumes one 100 MHz clock and an APB slave port with 32-bit data.
package qpc_pkg;

   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] QPC_ENCODER_CONTROL_OFS = 8'h00;
   localparam logic [7:0] QPC_INIT_VALUE_OFS = 8'h04;
   localparam logic [7:0] QPC_COMPARE_VALUE_OFS = 8'h08;
   localparam logic [7:0] QPC_POS_LOW_OFS = 8'h0C;
   localparam logic [7:0] QPC_POS_HIGH_OFS = 8'h10;
   localparam logic [7:0] QPC_MODULO_OFS = 8'h14;
   localparam logic [7:0] QPC_INPUT_CFG_OFS = 8'h18;
   localparam logic [7:0] QPC_STATUS_OFS = 8'h1C;

   // ---------------------------------------------------------------
   // Control register fields
   // ---------------------------------------------------------------
   localparam int QPC_ON_BIT = 15;
   localparam int QPC_IDLE_HALT_BIT = 13;
   localparam int QPC_PIMODE_LSB = 10;
   localparam int QPC_MATCH_B_BIT = 9;
   localparam int QPC_MATCH_A_BIT = 8;
   localparam int QPC_DIV_LSB = 4;
   localparam int QPC_CMODE_LSB = 0;
   localparam logic [15:0] QPC_CTRL_WMASK = 16'hBF7F;
   localparam logic [15:0] QPC_CTRL_RESET = 16'h0000;
   localparam logic [31:0] QPC_POS_RESET = 32'h0000_0000;
   localparam logic [31:0] QPC_MODULO_RESET = 32'hFFFF_FFFF;

   // ---------------------------------------------------------------
   // Modes
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      QPC_PI_NONE = 3'b000,
      QPC_PI_CLEAR = 3'b001,
      QPC_PI_NEXT = 3'b010,
      QPC_PI_HOME1 = 3'b011,
      QPC_PI_HOME2 = 3'b100,
      QPC_PI_CMP = 3'b101,
      QPC_PI_MOD = 3'b110,
      QPC_PI_RSVD = 3'b111
   } qpc_pimode_e;

   typedef enum logic [1:0] {
      QPC_HS_IDLE = 2'b00,
      QPC_HS_ARMED = 2'b01,
      QPC_HS_ONE = 2'b10
   } qpc_home_e;

   // Control fields as decoded by the counter logic
   typedef struct packed {
      logic on;
      logic idle_halt;
      logic [2:0] pimode;
      logic match_b;
      logic match_a;
      logic [2:0] divider;
      logic [1:0] cmode;
      logic swap;
      logic inv_a;
      logic inv_b;
   } qpc_ctrl_s;

   // Encoder pins
   typedef struct packed {
      logic phase_a;
      logic phase_b;
      logic index;
      logic home;
   } qpc_pins_s;

endpackage

// [hw/qpc_sync.sv]
// Two-stage synchroniser for a group of pin inputs.
// Assumes pins are asynchronous to clock.
`timescale 1ns/1ps
module qpc_sync #(
   parameter int WIDTH = 4
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_ff;

   // Only the second stage is read outside
   always_ff @(posedge clock) begin
      if (reset) begin
         meta_ff <= '0;
         sync_out <= '0;
      end else begin
         meta_ff <= async_in;
         sync_out <= meta_ff;
      end
   end
endmodule

// [hw/qpc_top.sv]
// Quadrature position counter with control register, APB slave.
// Assumes encoder pins are asynchronous and idle_mode comes from the
// power controller on the same clock.
// Operation
// (RULE1) With counters_on clear all counters stop but registers stay accessible.
// (RULE2) With idle_halt set the block stops while the device is idle.
// (RULE3) Init mode 000 ignores index; mode 001 clears position on every index.
// (RULE4) Init mode 010 loads the init value on the next index event.
// (RULE5) Modes 011/100 load the init value on the 1st/2nd index after home.
// (RULE6) Mode 101 clears position when it equals the compare value.
// (RULE7) Mode 110 counts modulo; 111 is reserved and does nothing.
// (RULE8) Bit 9 sets the phase B level needed for an index match.
// (RULE9) Bit 8 sets the phase A level needed for an index match.
// (RULE10) Counter modes 10 and 11 make the counters timers and ignore init mode.
// (RULE11) Counter mode 00 clears position on index with matching phases.
// (RULE12) Matched phases are taken after swap and inversion.
// (RULE13) Software picks a timer rate at least twice the count rate.
// (RULE14) Phase and index inputs are synchronised before use.
`timescale 1ns/1ps
module qpc_top
   import qpc_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Encoder and system
   input wire qpc_pkg::qpc_pins_s pins,
   input wire logic idle_mode,
   output logic [31:0] position_ff,
   output logic running_ff
);
   import qpc_pkg::*;

   logic [15:0] ctrl_ff;
   logic [2:0] incfg_ff;
   logic [31:0] init_ff, cmp_ff, mod_ff;
   qpc_ctrl_s cfg;
   qpc_pins_s pin_s;
   logic a_ff, b_ff, idx_ff, home_ff;
   logic ph_a, ph_b, idx_rise, home_rise, active;
   logic [1:0] hs_cnt_ff;
   qpc_home_e home_st_ff;
   logic load_pending_ff;
   logic [7:0] div_ff;
   logic tick;
   logic up, dn, step;
   logic wr, rd_ok, known;
   logic [31:0] nxt_pos;

   assign cfg = '{on: ctrl_ff[QPC_ON_BIT],
                  idle_halt: ctrl_ff[QPC_IDLE_HALT_BIT],
                  pimode: ctrl_ff[QPC_PIMODE_LSB +: 3],
                  match_b: ctrl_ff[QPC_MATCH_B_BIT],
                  match_a: ctrl_ff[QPC_MATCH_A_BIT],
                  divider: ctrl_ff[QPC_DIV_LSB +: 3],
                  cmode: ctrl_ff[QPC_CMODE_LSB +: 2],
                  swap: incfg_ff[0], inv_a: incfg_ff[1],
                  inv_b: incfg_ff[2]};

   // ---------------------------------------------------------------
   // Input synchronisation
   // ---------------------------------------------------------------
   qpc_sync #(.WIDTH(4)) u_sync ( // RULE14
      .clock(clock),
      .reset(reset),
      .async_in(pins),
      .sync_out(pin_s)
   );

   // Swap then invert, so index matching sees the conditioned phases
   assign ph_a = (cfg.swap ? pin_s.phase_b : pin_s.phase_a) ^ cfg.inv_a; // RULE12
   assign ph_b = (cfg.swap ? pin_s.phase_a : pin_s.phase_b) ^ cfg.inv_b; // RULE12
   assign active = cfg.on && !(cfg.idle_halt && idle_mode); // RULE1 RULE2

   always_ff @(posedge clock) begin
      if (reset) begin
         a_ff <= 1'b0;
         b_ff <= 1'b0;
         idx_ff <= 1'b0;
         home_ff <= 1'b0;
      end else begin
         a_ff <= ph_a;
         b_ff <= ph_b;
         idx_ff <= pin_s.index;
         home_ff <= pin_s.home;
      end
   end

   assign idx_rise = pin_s.index && !idx_ff;
   assign home_rise = pin_s.home && !home_ff;

   // Quadrature decode: x4, direction from the phase relation
   assign step = (ph_a ^ a_ff) ^ (ph_b ^ b_ff);
   assign up = step && (ph_a ^ b_ff);
   assign dn = step && !(ph_a ^ b_ff);

   // ---------------------------------------------------------------
   // Timer clock divider
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (reset || !active) begin
         div_ff <= 8'h00;
      end else if (div_ff >= ((8'h01 << cfg.divider) - 8'h01)) begin
         div_ff <= 8'h00;
      end else begin
         div_ff <= div_ff + 8'h01;
      end
   end
   assign tick = active &&
                 (div_ff >= ((8'h01 << cfg.divider) - 8'h01));

   // ---------------------------------------------------------------
   // Home tracking for the index-after-home modes
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (reset || !active) begin
         home_st_ff <= QPC_HS_IDLE;
      end else if (home_rise) begin
         home_st_ff <= QPC_HS_ARMED; // RULE5
      end else if (idx_rise) begin
         unique case (home_st_ff)
            QPC_HS_IDLE: home_st_ff <= QPC_HS_IDLE;
            QPC_HS_ARMED: home_st_ff <= (cfg.pimode == QPC_PI_HOME2) ?
                                        QPC_HS_ONE : QPC_HS_IDLE;
            QPC_HS_ONE: home_st_ff <= QPC_HS_IDLE;
            default: home_st_ff <= QPC_HS_IDLE;
         endcase
      end
   end

   // Mode 010 arms once per write of the control register
   always_ff @(posedge clock) begin
      if (reset) begin
         load_pending_ff <= 1'b0;
      end else if (wr && paddr == QPC_ENCODER_CONTROL_OFS) begin
         load_pending_ff <= 1'b1;
      end else if (active && idx_rise && cfg.pimode == QPC_PI_NEXT) begin
         load_pending_ff <= 1'b0; // RULE4
      end
   end

   // ---------------------------------------------------------------
   // Position counter
   // ---------------------------------------------------------------
   always_comb begin
      nxt_pos = position_ff;
      if (cfg.cmode[1]) begin
         if (tick) begin
            nxt_pos = position_ff + 32'h1; // RULE10
         end
      end else begin
         if (up) begin
            nxt_pos = (cfg.pimode == QPC_PI_MOD && position_ff == mod_ff) ?
                      32'h0 : position_ff + 32'h1; // RULE7
         end else if (dn) begin
            nxt_pos = (cfg.pimode == QPC_PI_MOD && position_ff == 32'h0) ?
                      mod_ff : position_ff - 32'h1; // RULE7
         end
         unique case (cfg.pimode)
            QPC_PI_CLEAR: if (idx_rise) nxt_pos = 32'h0; // RULE3
            QPC_PI_NEXT:
               if (idx_rise && load_pending_ff) nxt_pos = init_ff; // RULE4
            QPC_PI_HOME1:
               if (idx_rise && home_st_ff == QPC_HS_ARMED)
                  nxt_pos = init_ff; // RULE5
            QPC_PI_HOME2:
               if (idx_rise && home_st_ff == QPC_HS_ONE)
                  nxt_pos = init_ff; // RULE5
            QPC_PI_CMP:
               if (position_ff == cmp_ff) nxt_pos = 32'h0; // RULE6
            default: nxt_pos = nxt_pos; // RULE3 RULE7
         endcase
         if (cfg.cmode == 2'b00 && idx_rise && ph_a == cfg.match_a &&
             ph_b == cfg.match_b) begin // RULE8 RULE9
            nxt_pos = 32'h0; // RULE11
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         position_ff <= QPC_POS_RESET;
      end else if (wr && paddr == QPC_POS_LOW_OFS) begin
         position_ff <= {position_ff[31:16], pwdata[15:0]};
      end else if (wr && paddr == QPC_POS_HIGH_OFS) begin
         position_ff <= {pwdata[15:0], position_ff[15:0]};
      end else if (active) begin // RULE1 RULE2
         position_ff <= nxt_pos;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         running_ff <= 1'b0;
      end else begin
         running_ff <= active;
      end
   end

   // ---------------------------------------------------------------
   // APB slave, zero wait states
   // ---------------------------------------------------------------
   assign wr = psel && penable && pwrite && known;
   assign rd_ok = psel && !penable && !pwrite;
   assign known = paddr inside {QPC_ENCODER_CONTROL_OFS, QPC_INIT_VALUE_OFS,
      QPC_COMPARE_VALUE_OFS, QPC_POS_LOW_OFS, QPC_POS_HIGH_OFS,
      QPC_MODULO_OFS, QPC_INPUT_CFG_OFS, QPC_STATUS_OFS};

   always_ff @(posedge clock) begin
      if (reset) begin
         ctrl_ff <= QPC_CTRL_RESET;
         incfg_ff <= 3'h0;
         init_ff <= QPC_POS_RESET;
         cmp_ff <= QPC_POS_RESET;
         mod_ff <= QPC_MODULO_RESET;
      end else if (wr) begin // RULE1
         unique case (paddr)
            QPC_ENCODER_CONTROL_OFS: ctrl_ff <= pwdata[15:0] & QPC_CTRL_WMASK;
            QPC_INIT_VALUE_OFS: init_ff <= pwdata;
            QPC_COMPARE_VALUE_OFS: cmp_ff <= pwdata;
            QPC_MODULO_OFS: mod_ff <= pwdata;
            QPC_INPUT_CFG_OFS: incfg_ff <= pwdata[2:0];
            default: ctrl_ff <= ctrl_ff;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !known;
         if (rd_ok) begin
            unique case (paddr)
               QPC_ENCODER_CONTROL_OFS: prdata <= {16'h0, ctrl_ff};
               QPC_INIT_VALUE_OFS: prdata <= init_ff;
               QPC_COMPARE_VALUE_OFS: prdata <= cmp_ff;
               QPC_POS_LOW_OFS: prdata <= {16'h0, position_ff[15:0]};
               QPC_POS_HIGH_OFS: prdata <= {16'h0, position_ff[31:16]};
               QPC_MODULO_OFS: prdata <= mod_ff;
               QPC_INPUT_CFG_OFS: prdata <= {29'h0, incfg_ff};
               QPC_STATUS_OFS: prdata <= {25'h0, home_st_ff, load_pending_ff,
                  pin_s.home, pin_s.index, pin_s.phase_b, pin_s.phase_a};
               default: prdata <= 32'h0;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_stop_hold: assert property (@(posedge clock) disable iff (reset) // RULE1
      !cfg.on && !$past(wr) ##1 !$past(wr) |-> $stable(position_ff))
      else $error("position moved while counters off");
   a_idle_hold: assert property (@(posedge clock) disable iff (reset) // RULE2
      (cfg.on && cfg.idle_halt && idle_mode && !wr) |=> $stable(position_ff)
      || $past(wr))
      else $error("position moved while idle halted");
   a_idx_clear: assert property (@(posedge clock) disable iff (reset) // RULE3
      (active && !wr && cfg.cmode == 2'b01 && cfg.pimode == QPC_PI_CLEAR &&
      idx_rise) |=> position_ff == 32'h0)
      else $error("index did not clear position");
   a_next_load: assert property (@(posedge clock) disable iff (reset) // RULE4
      (active && !wr && cfg.cmode == 2'b01 && cfg.pimode == QPC_PI_NEXT &&
      idx_rise && load_pending_ff) |=> position_ff == $past(init_ff))
      else $error("next index did not load init value");
   a_home_load: assert property (@(posedge clock) disable iff (reset) // RULE5
      (active && !wr && cfg.cmode == 2'b01 && cfg.pimode == QPC_PI_HOME1 &&
      idx_rise && home_st_ff == QPC_HS_ARMED) |=>
      position_ff == $past(init_ff))
      else $error("index after home did not load");
   a_home2_load: assert property (@(posedge clock) disable iff (reset) // RULE5
      (active && !wr && cfg.cmode == 2'b01 && cfg.pimode == QPC_PI_HOME2 &&
      idx_rise && home_st_ff == QPC_HS_ONE) |=>
      position_ff == $past(init_ff))
      else $error("second index after home did not load");
   a_cmp_clear: assert property (@(posedge clock) disable iff (reset) // RULE6
      (active && !wr && cfg.cmode == 2'b01 && cfg.pimode == QPC_PI_CMP &&
      !idx_rise && position_ff == cmp_ff) |=> position_ff == 32'h0)
      else $error("compare match did not clear");
   a_mod_wrap: assert property (@(posedge clock) disable iff (reset) // RULE7
      (active && !wr && cfg.cmode == 2'b01 && cfg.pimode == QPC_PI_MOD &&
      up && position_ff == mod_ff) |=> position_ff == 32'h0)
      else $error("modulo count did not wrap");
   a_match_clr: assert property (@(posedge clock) disable iff (reset) // RULE11
      (active && !wr && cfg.cmode == 2'b00 && idx_rise &&
      ph_a == cfg.match_a && ph_b == cfg.match_b) |=>
      position_ff == 32'h0)
      else $error("index match did not clear");
   a_timer_mode: assert property (@(posedge clock) // RULE10
      disable iff (reset) (active && !wr && cfg.cmode[1] && !tick) |=>
      $stable(position_ff))
      else $error("timer moved without tick");
endmodule

// [verif/qpc_encoder_model.sv]
// Shaft encoder model driving the phase, index and home pins.
// Assumes callers run on the block clock and wait on its tasks.
`timescale 1ns/1ps
module qpc_encoder_model (
   // Clock
   input wire logic clock,
   // Encoder pins
   output qpc_pkg::qpc_pins_s pins
);
   import qpc_pkg::*;

   // ----------------------------------------------
   // Quadrature walk
   // ----------------------------------------------
   // Index 0..3 walks a,b through 00,10,11,01 so A leads B going up
   logic [1:0] quad;
   // Pins move at most once per GAP cycles, slow against the sampling
   localparam int GAP = 6;

   initial begin
      quad = 2'h0;
      pins = '0;
   end

   task automatic step(input bit up);
      quad = up ? quad + 2'h1 : quad - 2'h1;
      pins.phase_a <= quad[0] ^ quad[1];
      pins.phase_b <= quad[1];
      repeat (GAP) @(posedge clock);
   endtask

   task automatic pulse(input bit home);
      if (home) pins.home <= 1'b1;
      else pins.index <= 1'b1;
      repeat (GAP) @(posedge clock);
      pins.home <= 1'b0;
      pins.index <= 1'b0;
      repeat (GAP) @(posedge clock);
   endtask
endmodule

// [verif/qpc_top_tb.sv]
// Self-checking bench for the quadrature position counter block.
// Assumes the encoder model shares the 100 MHz block clock.
`timescale 1ns/1ps
module qpc_top_tb;
   import qpc_pkg::*;
   logic clock, reset, psel, penable, pwrite, pready, pslverr, err;
   logic idle_mode, running_ff;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, position_ff, rd, p, q;
   logic [2:0] cfg, dv;
   logic [1:0] lv;
   qpc_pins_s pins;
   int error_cnt = 0;
   int samples_checked = 0;
   int cycles = 0;
   int n;

   qpc_top i_qpc_top(.clock(clock), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
      .idle_mode(idle_mode), .position_ff(position_ff),
      .running_ff(running_ff));
   qpc_encoder_model i_qpc_encoder_model(.clock(clock), .pins(pins));

   // ----------------------------------------------
   // Clock, timeout and reporting
   // ----------------------------------------------
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // The full sequence needs under two thousand cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         results();
      end
   end

   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic results();
      $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------------
   // Bus and encoder helpers
   // ----------------------------------------------
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask

   task automatic setpos(input logic [31:0] v);
      apb(1'b1, QPC_POS_LOW_OFS, {16'h0000, v[15:0]});
      apb(1'b1, QPC_POS_HIGH_OFS, {16'h0000, v[31:16]});
   endtask

   task automatic ctl(input logic on, halt, input logic [2:0] pim,
      input logic [1:0] cm, m);
      apb(1'b1, QPC_ENCODER_CONTROL_OFS,
         {16'h0000, on, 1'b0, halt, pim, m, 1'b0, dv, 2'b00, cm});
   endtask

   function automatic logic [1:0] eff_ba(input logic [2:0] c);
      logic a, b;
      a = c[0] ? pins.phase_b : pins.phase_a;
      b = c[0] ? pins.phase_a : pins.phase_b;
      return {b ^ c[2], a ^ c[1]};
   endfunction

   // Counter mode 01 keeps the phase-match clear out of the init mode
   // tests; levels opposite the phases as a second guard
   task automatic mode(input logic [2:0] pim);
      ctl(1'b1, 1'b0, pim, 2'b01, ~eff_ba(3'h0));
   endtask

   task automatic up(input int k);
      repeat (k) i_qpc_encoder_model.step(1'b1);
   endtask

   task automatic ev(input bit h);
      i_qpc_encoder_model.pulse(h);
   endtask

   // ----------------------------------------------
   // Test sequence
   // ----------------------------------------------
   initial begin
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      idle_mode = 1'b0;
      dv = 3'h0;
      n = $urandom(32'hB66C);
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      apb(1'b0, QPC_ENCODER_CONTROL_OFS, 32'h0);
      check("control reset", rd, {16'h0000, QPC_CTRL_RESET});
      apb(1'b0, QPC_MODULO_OFS, 32'h0);
      check("modulo reset", rd, QPC_MODULO_RESET);
      q = $urandom & 32'h0000_7FFF;
      apb(1'b1, QPC_ENCODER_CONTROL_OFS, q);
      apb(1'b0, QPC_ENCODER_CONTROL_OFS, 32'h0);
      check("control", rd, q & {16'h0000, QPC_CTRL_WMASK});
      apb(1'b0, 8'h20, 32'h0);
      check("unmapped error", err, 1'b1);
      p = $urandom;
      setpos(p);
      up(3);
      check("position off", position_ff, p);
      check("running off", running_ff, 1'b0);
      $display("test registers done");
      mode(QPC_PI_NONE);
      n = $urandom_range(6, 1);
      fork
         i_qpc_encoder_model.step(1'b1);
         begin
            repeat (2) @(posedge clock);
            check("position early", position_ff, p);
         end
      join
      up(n);
      i_qpc_encoder_model.step(1'b0);
      p = p + n;
      check("position count", position_ff, p);
      check("running", running_ff, 1'b1);
      idle_mode <= 1'b1;
      ctl(1'b1, 1'b1, QPC_PI_NONE, 2'b00, 2'b00);
      up(1);
      check("idle halted", position_ff, p);
      check("running halted", running_ff, 1'b0);
      ctl(1'b1, 1'b0, QPC_PI_NONE, 2'b00, 2'b00);
      up(1);
      p = p + 1;
      check("idle counting", position_ff, p);
      idle_mode <= 1'b0;
      $display("test count and idle done");
      q = $urandom;
      apb(1'b1, QPC_INIT_VALUE_OFS, q);
      mode(QPC_PI_NONE);
      ev(1'b0);
      check("mode 000", position_ff, p);
      mode(QPC_PI_CLEAR);
      ev(1'b0);
      check("mode 001", position_ff, 32'h0);
      mode(QPC_PI_NEXT);
      setpos(p);
      ev(1'b0);
      check("mode 010 load", position_ff, q);
      up(4);
      ev(1'b0);
      check("mode 010 once", position_ff, q + 4);
      mode(QPC_PI_HOME1);
      setpos(p);
      ev(1'b0);
      check("mode 011 no home", position_ff, p);
      ev(1'b1);
      ev(1'b0);
      check("mode 011 load", position_ff, q);
      mode(QPC_PI_HOME2);
      setpos(p);
      ev(1'b1);
      ev(1'b0);
      check("mode 100 first", position_ff, p);
      ev(1'b0);
      check("mode 100 second", position_ff, q);
      mode(QPC_PI_RSVD);
      setpos(p);
      ev(1'b0);
      check("mode 111", position_ff, p);
      apb(1'b1, QPC_COMPARE_VALUE_OFS, p + 2);
      mode(QPC_PI_CMP);
      setpos(p);
      up(1);
      check("mode 101 below", position_ff, p + 1);
      up(1);
      check("mode 101 equal", position_ff, 32'h0);
      n = $urandom_range(5, 2);
      apb(1'b1, QPC_MODULO_OFS, n);
      mode(QPC_PI_MOD);
      setpos(32'h0);
      up(7);
      check("mode 110", position_ff, 7 % (n + 1));
      apb(1'b1, QPC_MODULO_OFS, QPC_MODULO_RESET);
      $display("test init modes done");
      // Swap with a single inversion is left out: its order is open
      for (int k = 0; k < 8; k++) begin
         cfg = 3'($urandom);
         if (cfg[0]) cfg[2] = cfg[1];
         apb(1'b1, QPC_INPUT_CFG_OFS, {29'h0, cfg});
         lv = k[2] ? eff_ba(cfg) : 2'(k);
         ctl(1'b1, 1'b0, QPC_PI_NONE, 2'b00, lv);
         p = $urandom | 32'h1;
         setpos(p);
         ev(1'b0);
         q = (lv === eff_ba(cfg)) ? 32'h0 : p;
         check("index match", position_ff, q);
      end
      apb(1'b1, QPC_INPUT_CFG_OFS, 32'h0);
      $display("test index match done");
      dv = 3'h7;
      for (int m = 2; m < 4; m++) begin
         p = $urandom & 32'hFFFF_0FFF;
         ctl(1'b1, 1'b0, QPC_PI_CLEAR, 2'(m), 2'b00);
         setpos(p);
         ev(1'b0);
         q = position_ff - p;
         check("timer ignores index", q < 32'h2, 1'b1);
         repeat (300) @(posedge clock);
         q = position_ff - p;
         check("timer ticks", q > 32'h1 && q < 32'h5, 1'b1);
      end
      ctl(1'b0, 1'b0, QPC_PI_NONE, 2'b11, 2'b00);
      setpos(p);
      repeat (300) @(posedge clock);
      check("timer off", position_ff, p);
      $display("test timer done");
      results();
   end
endmodule
